// ===== pkg/uwa_regs.vh
// constants for the wake-on-receive and auto-baud measurement controller
//
// Contract
// - wake enable set, async mode: watch receive pin, interrupt on falling edge
// - after that falling edge, hardware clears wake enable on next rising edge
// - wake enable clear: no monitoring and no rising edge detection
// - synchronous mode: wake enable write ignored, bit has no effect
// - auto-baud enable in async mode measures baud on next character
// - measurement done: hardware clears auto-baud enable, zero means off or done
// - config bit picks 16-bit or 8-bit generator, sets measured count width
`ifndef UWA_REGS_VH
`define UWA_REGS_VH

// ----------------------------------------------------------------------------
// field positions of the control bits
// ----------------------------------------------------------------------------
`define UWA_WAKE_BIT 1
`define UWA_ABD_BIT 0

// ----------------------------------------------------------------------------
// auto-baud measurement
// ----------------------------------------------------------------------------
// a 55h character gives 5 falling edges: start bit and four data lows
`define UWA_ABD_FALLS 3'h5
// measured span covers 8 bit times; value = span / 8 ... stored as span / 8 - 1
`define UWA_ABD_SHIFT 3
`define UWA_CNT_W 19

`endif

// ===== sim/tb.sv
// self-checking bench for the wake and auto-baud controller
`timescale 1ns/1ns
module tb;
  reg clk = 1'b0, reset = 1'b1, sync_mode = 1'b0, brg16_sel = 1'b0, go = 1'b0;
  reg wake_set = 1'b0, wake_clr = 1'b0, abd_set = 1'b0, abd_clr = 1'b0;
  reg [7:0] dat = 8'h00;
  reg [15:0] per = 16'h0010, got = 16'h0000, ev;
  wire rx_pin, wake_on_rx_enable, auto_baud_measure_enable, wake_irq, baud_valid, busy;
  wire [15:0] baud_value;
  integer error_cnt = 0, checks_done = 0, irqs = 0, vals = 0, cyc = 0, i, n0;
  integer seed = 32'hfa9f0173;
  always #5 clk = ~clk;
  uwa_ctrl DUT (.clk(clk), .reset(reset), .rx_pin(rx_pin), .sync_mode(sync_mode),
    .brg16_sel(brg16_sel), .wake_set(wake_set), .wake_clr(wake_clr), .abd_set(abd_set),
    .abd_clr(abd_clr), .wake_on_rx_enable(wake_on_rx_enable), .wake_irq(wake_irq),
    .auto_baud_measure_enable(auto_baud_measure_enable), .baud_value(baud_value),
    .baud_valid(baud_valid));
  uwa_tx TX (.clk(clk), .go(go), .dat(dat), .per(per), .rx(rx_pin), .busy(busy));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wake_irq === 1'b1) irqs <= irqs + 1;
    if (baud_valid === 1'b1) begin
      vals <= vals + 1;
      got <= baud_value;
    end
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task pulse(input [3:0] m);
    begin
      @(posedge clk) {wake_set, wake_clr, abd_set, abd_clr} <= m;
      @(posedge clk) {wake_set, wake_clr, abd_set, abd_clr} <= 4'h0;
      #1;
    end
  endtask
  task send;
    begin
      @(posedge clk) go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      @(negedge busy);
      repeat (8) @(posedge clk);
    end
  endtask
  // 8-bit generator cannot hold more than one byte, so it pins at the top
  function [15:0] exp_baud(input [15:0] p, input b);
    exp_baud = (b || p <= 16'h0100) ? p - 16'h0001 : 16'h00FF;
  endfunction
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    pulse(4'h8);
    chk("wake", 1, wake_on_rx_enable);
    pulse(4'h4);
    chk("wclr", 0, wake_on_rx_enable);
    pulse(4'h2);
    pulse(4'h1);
    chk("aclr", 0, auto_baud_measure_enable);
    for (i = 0; i < 4; i = i + 1) begin
      pulse(4'h8);
      dat <= $random(seed);
      n0 = irqs;
      send;
      chk("irq", n0 + 1, irqs);
      chk("wake", 0, wake_on_rx_enable);
    end
    $display("wake test done");
    pulse(4'h8);
    sync_mode <= 1'b1;
    pulse(4'h4);
    pulse(4'h2);
    chk("sync", 16'h0002, {wake_on_rx_enable, auto_baud_measure_enable});
    n0 = irqs;
    send;
    chk("sirq", n0, irqs);
    chk("swake", 1, wake_on_rx_enable);
    sync_mode <= 1'b0;
    pulse(4'h4);
    chk("wclr", 0, wake_on_rx_enable);
    $display("sync test done");
    for (i = 0; i < 5; i = i + 1) begin
      per <= (i < 2) ? 16'h012C : 16'h0010 + ($random(seed) & 16'h003F);
      brg16_sel <= (i < 2) ? i[0] : $random(seed);
      n0 = vals;
      pulse(4'h2);
      chk("aset", 1, auto_baud_measure_enable);
      dat <= 8'h55;
      send;
      ev = exp_baud(per, brg16_sel);
      chk("valid", n0 + 1, vals);
      chk("abd", 0, auto_baud_measure_enable);
      chk("baud", ev, got);
    end
    $display("auto-baud test done");
    end_sim;
  end
endmodule // tb
bind uwa_ctrl uwa_props P (.clk(clk), .reset(reset), .rx_pin(rx_pin), .sync_mode(sync_mode),
  .brg16_sel(brg16_sel), .wake_set(wake_set), .wake_clr(wake_clr), .abd_set(abd_set),
  .abd_clr(abd_clr), .wake_on_rx_enable(wake_on_rx_enable), .wake_irq(wake_irq),
  .auto_baud_measure_enable(auto_baud_measure_enable), .baud_value(baud_value),
  .baud_valid(baud_valid));

// ===== sim/uwa_props.sv
// port checks for the wake and auto-baud controller
`timescale 1ns/1ns
module uwa_props (
  input wire clk,
  input wire reset,
  input wire rx_pin,
  input wire sync_mode,
  input wire brg16_sel,
  input wire wake_set,
  input wire wake_clr,
  input wire abd_set,
  input wire abd_clr,
  input wire wake_on_rx_enable,
  input wire auto_baud_measure_enable,
  input wire wake_irq,
  input wire [15:0] baud_value,
  input wire baud_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_IRQ: assert property (wake_irq |-> $past(wake_on_rx_enable)) else $error("irq");
  AST_SYN: assert property (wake_irq |-> !$past(rx_pin, 4) && $past(rx_pin, 5))
    else $error("irq lag");
  AST_RISE: assert property ($fell(wake_on_rx_enable) && !$past(wake_clr) |->
    $past(rx_pin, 4) && !$past(rx_pin, 5)) else $error("wake clr");
  AST_OFF: assert property (!$past(wake_on_rx_enable) && !$past(wake_set) |->
    !wake_on_rx_enable && !wake_irq) else $error("wake off");
  AST_SMD: assert property ($past(sync_mode) && !$past(wake_clr) |->
    $stable(wake_on_rx_enable)) else $error("sync");
  AST_ASET: assert property (abd_set && !sync_mode |=> auto_baud_measure_enable)
    else $error("abd set");
  AST_ADONE: assert property (baud_valid |-> !auto_baud_measure_enable &&
    $past(auto_baud_measure_enable)) else $error("abd done");
  AST_W8: assert property (baud_valid && !brg16_sel |-> baud_value[15:8] == 8'h00)
    else $error("width");
  cover property (wake_irq);
  cover property ($fell(wake_on_rx_enable));
  cover property (baud_valid);
endmodule // uwa_props

// ===== sim/uwa_tx.sv
// remote serial transmitter: start, 8 data lsb first, stop
`timescale 1ns/1ns
module uwa_tx (
  input wire clk,
  input wire go,
  input wire [7:0] dat,
  input wire [15:0] per,
  output reg rx,
  output reg busy
);
  reg [9:0] w;
  integer i;
  initial begin
    rx = 1'b1;
    busy = 1'b0;
  end
  always @(posedge clk) if (go && !busy) begin
    busy <= 1'b1;
    w = {1'b1, dat, 1'b0};
    for (i = 0; i < 10; i = i + 1) begin
      rx <= w[i];
      repeat (per) @(posedge clk);
    end
    busy <= 1'b0;
  end
endmodule // uwa_tx

// ===== verilog/uwa_ctrl.v
// wake-on-receive monitor and auto-baud rate measurement controller
`timescale 1ns/1ns
`include "uwa_regs.vh"

module uwa_ctrl (
  clk,
  reset,
  rx_pin,
  sync_mode,
  brg16_sel,
  wake_set,
  wake_clr,
  abd_set,
  abd_clr,
  wake_on_rx_enable,
  auto_baud_measure_enable,
  wake_irq,
  baud_value,
  baud_valid
);
  input wire clk;
  input wire reset;
  input wire rx_pin;
  input wire sync_mode;
  input wire brg16_sel;
  input wire wake_set;
  input wire wake_clr;
  input wire abd_set;
  input wire abd_clr;
  output reg wake_on_rx_enable;
  output reg auto_baud_measure_enable;
  output reg wake_irq;
  output reg [15:0] baud_value;
  output reg baud_valid;

  // --------------------------------------------------------------------------
  // receive pin synchroniser
  // --------------------------------------------------------------------------
  // three stages; a level counts only once stages two and three agree
  reg rx_s1_r;
  reg rx_s2_r;
  reg rx_s3_r;
  reg rx_lvl_r;
  wire rx_agree;
  wire rx_fall;
  wire rx_rise;

  // a transition is one the held level has not yet taken, in the wanted direction
  function edge_at;
    input agree;
    input held;
    input now;
    input want_rise;
    begin
      edge_at = agree && (held != now) && (now == want_rise);
    end
  endfunction

  assign rx_agree = (rx_s2_r == rx_s3_r);
  assign rx_fall = edge_at(rx_agree, rx_lvl_r, rx_s3_r, 1'b0);
  assign rx_rise = edge_at(rx_agree, rx_lvl_r, rx_s3_r, 1'b1);

  always @(posedge clk) begin
    if (reset) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_agree) begin
        rx_lvl_r <= rx_s3_r;
      end
    end
  end

  // --------------------------------------------------------------------------
  // wake-on-receive
  // --------------------------------------------------------------------------
  reg fall_seen_r;

  always @(posedge clk) begin
    if (reset) begin
      wake_on_rx_enable <= 1'b0;
      fall_seen_r <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      wake_irq <= 1'b0;
      if (sync_mode) begin
        // writes dropped; a pending wake sequence is abandoned
        fall_seen_r <= 1'b0;
      end else if (wake_on_rx_enable) begin
        if (rx_fall) begin
          wake_irq <= 1'b1;
          fall_seen_r <= 1'b1;
        end else if (rx_rise && fall_seen_r) begin
          wake_on_rx_enable <= 1'b0;
          fall_seen_r <= 1'b0;
        end else if (wake_clr) begin
          wake_on_rx_enable <= 1'b0;
          fall_seen_r <= 1'b0;
        end
      end else begin
        fall_seen_r <= 1'b0;
        if (wake_set && !wake_clr) begin
          wake_on_rx_enable <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // auto-baud measurement
  // --------------------------------------------------------------------------
  // counts from the start-bit fall to the fifth fall: eight bit times of 55h
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_MEAS = 2'b10;

  reg [1:0] abd_state_r;
  reg [1:0] abd_state_nxt;
  reg abd_en_nxt;
  reg [2:0] fall_cnt_r;
  reg [2:0] fall_cnt_nxt;
  reg [`UWA_CNT_W-1:0] span_r;
  reg [`UWA_CNT_W-1:0] span_nxt;
  reg [15:0] baud_nxt;
  reg valid_nxt;
  wire [`UWA_CNT_W-1:0] per_bit;
  wire abd_abort;
  wire last_fall;

  // span_r counts whole cycles since the start-bit fall, so eight bits give 8 x period
  assign per_bit = span_r >> `UWA_ABD_SHIFT;
  assign abd_abort = abd_clr | sync_mode;
  assign last_fall = rx_fall & (fall_cnt_r == `UWA_ABD_FALLS - 3'h1);

  // 8-bit generator keeps only the low byte, saturating on overflow
  function [15:0] fit_width;
    input [`UWA_CNT_W-1:0] v;
    input wide;
    begin
      if (wide) begin
        fit_width = (v > 19'h0FFFF) ? 16'hFFFF : v[15:0];
      end else begin
        fit_width = (v > 19'h000FF) ? 16'h00FF : {8'h00, v[7:0]};
      end
    end
  endfunction

  always @* begin
    abd_state_nxt = abd_state_r;
    abd_en_nxt = auto_baud_measure_enable;
    fall_cnt_nxt = fall_cnt_r;
    span_nxt = span_r;
    baud_nxt = baud_value;
    valid_nxt = 1'b0;
    case (abd_state_r)
      ST_IDLE: begin
        if (abd_set && !sync_mode) begin
          abd_en_nxt = 1'b1;
          abd_state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (abd_abort) begin
          abd_en_nxt = 1'b0;
          abd_state_nxt = ST_IDLE;
        end else if (rx_fall) begin
          // start bit of the next character opens the window
          fall_cnt_nxt = 3'h1;
          span_nxt = {{(`UWA_CNT_W-1){1'b0}}, 1'b1};
          abd_state_nxt = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (abd_abort) begin
          // abort keeps the last good value
          abd_en_nxt = 1'b0;
          abd_state_nxt = ST_IDLE;
        end else if (last_fall) begin
          baud_nxt = fit_width(per_bit - 1'b1, brg16_sel);
          valid_nxt = 1'b1;
          abd_en_nxt = 1'b0;
          abd_state_nxt = ST_IDLE;
        end else begin
          if (span_r != {`UWA_CNT_W{1'b1}}) begin
            // saturates so a stuck line cannot wrap into a small value
            span_nxt = span_r + 1'b1;
          end
          if (rx_fall) begin
            fall_cnt_nxt = fall_cnt_r + 3'h1;
          end
        end
      end
      default: begin
        abd_en_nxt = 1'b0;
        abd_state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      abd_state_r <= ST_IDLE;
      auto_baud_measure_enable <= 1'b0;
      fall_cnt_r <= 3'h0;
      span_r <= {`UWA_CNT_W{1'b0}};
      baud_value <= 16'h0000;
      baud_valid <= 1'b0;
    end else begin
      abd_state_r <= abd_state_nxt;
      auto_baud_measure_enable <= abd_en_nxt;
      fall_cnt_r <= fall_cnt_nxt;
      span_r <= span_nxt;
      baud_value <= baud_nxt;
      baud_valid <= valid_nxt;
    end
  end

endmodule // uwa_ctrl
